// ===== hdl/fcs_err_scale.sv
`timescale 1ns/10ps
module fcs_err_scale #(
  parameter int W = 32
) (
  // Error carried into the next rotation
  input  wire logic signed [W-1:0]              err_in,
  input  wire logic        [fcs_pkg::MULT_W-1:0] mult_pct,
  output logic signed      [W-1:0]              err_out
);

  // ==========================================================
  // Keep (100 - pct) percent; division truncates toward zero
  logic        [fcs_pkg::MULT_W-1:0] keep_pct;
  logic signed [W+8:0]               product;
  logic signed [W+8:0]               quotient;

  assign keep_pct = fcs_pkg::MULT_MAX - mult_pct;
  assign product  = (W+9)'(err_in) * $signed({2'h0, keep_pct});
  assign quotient = product / $signed((W+9)'(fcs_pkg::MULT_MAX));
  assign err_out  = quotient[W-1:0];

endmodule // fcs_err_scale

// ===== hdl/fcs_mon_chan.sv
`timescale 1ns/10ps
module fcs_mon_chan #(
  parameter int W     = 32,
  parameter int OUT_W = 16
) (
  // Clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            srst,
  // Selector and source
  input  wire logic [fcs_pkg::SEL_W-1:0]       sel,
  input  wire logic signed [W-1:0]             err,
  // Monitor level, one count per 0.01 V
  output logic signed [OUT_W-1:0]              mon_out
);

  localparam logic signed [W-1:0] POS_LIM = W'((1 << (OUT_W-1)) - 1);
  localparam logic signed [W-1:0] NEG_LIM = -POS_LIM;

  logic signed [OUT_W-1:0] sat_err;
  logic signed [OUT_W-1:0] next_mon;

  // Saturate so a large error pins the monitor instead of wrapping
  assign sat_err  = (err > POS_LIM) ? POS_LIM[OUT_W-1:0] :
                    (err < NEG_LIM) ? NEG_LIM[OUT_W-1:0] : err[OUT_W-1:0];
  assign next_mon = (sel == fcs_pkg::MON_CODE_ERR) ? sat_err : '0; // (R5)

  always_ff @(posedge core_clk)
  begin
    if (srst)
      mon_out <= '0;
    else
      mon_out <= next_mon;
  end

  mon_err_a: assert property (@(posedge core_clk) disable iff (srst) // (R5)
    (sel == fcs_pkg::MON_CODE_ERR) |=> (mon_out == $past(sat_err)))
    else $error("monitor does not show motor-load error");

endmodule // fcs_mon_chan

// ===== hdl/fcs_supervisor.sv
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
// Functional notes
// (R1) Fully-closed: raise overflow alarm when motor-load error exceeds programmed limit.
// (R2) Limit zero disables the overflow alarm entirely.
// (R3) Each new rotation starts with previous error scaled by (100 - multiplier)%.
// (R4) Multiplier zero: load reading used as is, no carried correction.
// (R5) Monitor code 07 outputs motor-load error at 0.01 V per unit.
// (R6) Speed feedback source: 0 motor, 1 external; applied only at restart.
// (R7) Speed feedback source ignored while loop control mode digit is 0.
// (R8) Group-one alarm stops motor per group-one method, default dynamic brake.
// (R9) Group-two alarm stops motor per group-two method, default zero speed.
// (R10) Under torque control every alarm uses the group-one stop method.
// (R11) Group-two method 1 means stop exactly as group one.
// (R12) Parameter alarm when option module and loop control mode disagree.
// (R13) Limit and multiplier act at once; overflow alarm latched until alarm reset.
module fcs_supervisor #(
  parameter int POS_W = 32,
  parameter int MON_W = 16
) (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     srst,
  // Register port
  input  wire logic [7:0]               reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [31:0]              reg_rdata,
  // Position feedback
  input  wire logic [POS_W-1:0]         motor_pos,
  input  wire logic [POS_W-1:0]         load_pos,
  input  wire logic                     pos_valid,
  input  wire logic                     rotation_tick,
  // Operating conditions
  input  wire logic                     torque_ctrl,
  input  wire logic                     option_fc_pin,
  input  wire logic                     group1_alarm_in,
  input  wire logic                     group2_alarm_in,
  // Alarms and stop request
  output logic                          motor_load_error_overflow_alarm,
  output logic                          param_setting_alarm,
  output logic                          stop_req,
  output fcs_pkg::fcs_stop_e            stop_action,
  // Speed feedback source
  output logic                          speed_fb_external,
  // Analog monitors
  output logic signed [MON_W-1:0]       mon1_out,
  output logic signed [MON_W-1:0]       mon2_out
);

  // ==========================================================
  // Software settings
  logic [fcs_pkg::DIGIT_W-1:0] loop_control_mode_digit;
  logic [fcs_pkg::DIGIT_W-1:0] speed_feedback_source_select;
  logic [fcs_pkg::DIGIT_W-1:0] group1_stop_method;
  logic [fcs_pkg::DIGIT_W-1:0] group2_stop_method;
  logic [fcs_pkg::LIMIT_W-1:0] motor_load_error_limit;
  logic [fcs_pkg::MULT_W-1:0]  per_rotation_error_multiplier;
  logic [fcs_pkg::SEL_W-1:0]   analog_monitor1_select;
  logic [fcs_pkg::SEL_W-1:0]   analog_monitor2_select;

  wire wr_ctrl  = reg_wr && (reg_addr == fcs_pkg::ADDR_CTRL);
  wire wr_limit = reg_wr && (reg_addr == fcs_pkg::ADDR_LIMIT);
  wire wr_mult  = reg_wr && (reg_addr == fcs_pkg::ADDR_MULT);
  wire wr_mon   = reg_wr && (reg_addr == fcs_pkg::ADDR_MON_SEL);
  wire wr_cmd   = reg_wr && (reg_addr == fcs_pkg::ADDR_CMD);
  wire alarm_reset = wr_cmd && reg_wdata[fcs_pkg::CMD_ALM_RST];
  wire restart     = wr_cmd && reg_wdata[fcs_pkg::CMD_RESTART];

  // Out-of-range settings clamp to the top of their range
  wire [fcs_pkg::LIMIT_W-1:0] limit_wdata =
    (reg_wdata > 32'(fcs_pkg::LIMIT_MAX)) ? fcs_pkg::LIMIT_MAX : reg_wdata[fcs_pkg::LIMIT_W-1:0];
  wire [fcs_pkg::MULT_W-1:0] mult_wdata =
    (reg_wdata > 32'(fcs_pkg::MULT_MAX)) ? fcs_pkg::MULT_MAX : reg_wdata[fcs_pkg::MULT_W-1:0];

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      loop_control_mode_digit      <= fcs_pkg::DIGIT_RST;
      speed_feedback_source_select <= fcs_pkg::DIGIT_RST;
      group1_stop_method           <= fcs_pkg::DIGIT_RST;
      group2_stop_method           <= fcs_pkg::DIGIT_RST;
    end
    else if (wr_ctrl)
    begin
      loop_control_mode_digit      <= reg_wdata[fcs_pkg::CTRL_MODE_LSB +: fcs_pkg::DIGIT_W];
      speed_feedback_source_select <= reg_wdata[fcs_pkg::CTRL_FBSEL_LSB +: fcs_pkg::DIGIT_W];
      group1_stop_method           <= reg_wdata[fcs_pkg::CTRL_G1_LSB +: fcs_pkg::DIGIT_W];
      group2_stop_method           <= reg_wdata[fcs_pkg::CTRL_G2_LSB +: fcs_pkg::DIGIT_W];
    end
  end

  // Limit and multiplier act from the next cycle on
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      motor_load_error_limit        <= fcs_pkg::LIMIT_RST;
      per_rotation_error_multiplier <= fcs_pkg::MULT_RST;
      analog_monitor1_select        <= fcs_pkg::MON1_RST;
      analog_monitor2_select        <= fcs_pkg::MON2_RST;
    end
    else
    begin
      if (wr_limit)
        motor_load_error_limit <= limit_wdata; // (R13)
      if (wr_mult)
        per_rotation_error_multiplier <= mult_wdata; // (R13)
      if (wr_mon)
      begin
        analog_monitor1_select <= reg_wdata[fcs_pkg::MON1_LSB +: fcs_pkg::SEL_W];
        analog_monitor2_select <= reg_wdata[fcs_pkg::MON2_LSB +: fcs_pkg::SEL_W];
      end
    end
  end

  // ==========================================================
  // Option module strap, two-stage synchroniser
  logic option_meta;
  logic option_sync;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      option_meta <= 1'b0;
      option_sync <= 1'b0;
    end
    else
    begin
      option_meta <= option_fc_pin;
      option_sync <= option_meta;
    end
  end

  wire fully_closed = (loop_control_mode_digit != fcs_pkg::DIGIT_RST);

  // ==========================================================
  // Motor-load error with per-rotation carry
  logic signed [POS_W-1:0] raw_err;
  logic signed [POS_W-1:0] err_base;
  logic signed [POS_W-1:0] carried_err;

  wire signed [POS_W-1:0] eff_err = raw_err - err_base;
  wire        [POS_W-1:0] err_abs = eff_err[POS_W-1] ? POS_W'(-eff_err) : eff_err;
  wire                    mult_zero = (per_rotation_error_multiplier == '0);

  fcs_err_scale #(
    .W        (POS_W)
  ) u_scale (
    .err_in   (eff_err),
    .mult_pct (per_rotation_error_multiplier),
    .err_out  (carried_err)
  );

  always_ff @(posedge core_clk)
  begin
    if (srst)
      raw_err <= '0;
    else if (pos_valid)
      raw_err <= motor_pos - load_pos;
  end

  // New base makes the error restart at its scaled value
  always_ff @(posedge core_clk)
  begin
    if (srst)
      err_base <= '0;
    else if (mult_zero)
      err_base <= '0; // (R4)
    else if (rotation_tick && !pos_valid)
      err_base <= raw_err - carried_err; // (R3)
  end

  // ==========================================================
  // Alarms
  wire limit_on    = (motor_load_error_limit != '0);
  wire over_limit  = fully_closed && limit_on && (err_abs > POS_W'(motor_load_error_limit)); // (R1) (R2)
  wire param_clash = option_sync != fully_closed; // (R12)

  // A new overflow beats a reset arriving in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (srst)
      motor_load_error_overflow_alarm <= 1'b0;
    else if (over_limit)
      motor_load_error_overflow_alarm <= 1'b1; // (R1)
    else if (alarm_reset)
      motor_load_error_overflow_alarm <= 1'b0; // (R13)
  end

  // Alarm reset cannot clear this one; only srst does
  always_ff @(posedge core_clk)
  begin
    if (srst)
      param_setting_alarm <= 1'b0;
    else if (param_clash)
      param_setting_alarm <= 1'b1; // (R12)
  end

  // ==========================================================
  // Speed feedback source, sampled at restart only
  logic fb_ext_pending;

  always_ff @(posedge core_clk)
  begin
    if (srst)
      fb_ext_pending <= 1'b0;
    else if (restart)
      fb_ext_pending <= (speed_feedback_source_select == fcs_pkg::FB_EXTERNAL); // (R6)
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      speed_fb_external <= 1'b0;
    else
      speed_fb_external <= fb_ext_pending && fully_closed; // (R7)
  end

  // ==========================================================
  // Stop method selection
  wire group1_hit = group1_alarm_in || motor_load_error_overflow_alarm || param_setting_alarm;
  wire group2_hit = group2_alarm_in;

  wire fcs_pkg::fcs_stop_e g1_action = (group1_stop_method == fcs_pkg::DIGIT_RST) ?
                                       fcs_pkg::STOP_BRAKE : fcs_pkg::STOP_COAST; // (R8)
  wire g2_as_g1 = torque_ctrl || (group2_stop_method == fcs_pkg::G2_SAME_G1); // (R10) (R11)
  wire fcs_pkg::fcs_stop_e g2_action = g2_as_g1 ? g1_action : fcs_pkg::STOP_ZERO_SPEED; // (R9)
  wire fcs_pkg::fcs_stop_e next_action = group1_hit ? g1_action :
                                         group2_hit ? g2_action : fcs_pkg::STOP_NONE;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      stop_action <= fcs_pkg::STOP_NONE;
      stop_req    <= 1'b0;
    end
    else
    begin
      stop_action <= next_action;
      stop_req    <= group1_hit || group2_hit;
    end
  end

  // ==========================================================
  // Analog monitor channels
  logic [fcs_pkg::SEL_W-1:0]  mon_sel [2];
  logic signed [MON_W-1:0]    mon_val [2];

  assign mon_sel[0] = analog_monitor1_select;
  assign mon_sel[1] = analog_monitor2_select;
  assign mon1_out   = mon_val[0];
  assign mon2_out   = mon_val[1];

  for (genvar ch = 0; ch < 2; ch++)
  begin : g_mon
    fcs_mon_chan #(
      .W        (POS_W),
      .OUT_W    (MON_W)
    ) u_mon (
      .core_clk (core_clk),
      .srst     (srst),
      .sel      (mon_sel[ch]),
      .err      (eff_err),
      .mon_out  (mon_val[ch])
    );
  end

  // ==========================================================
  // Read path, data valid only in the cycle after the strobe
  wire [31:0] ctrl_word = {16'h0000, group2_stop_method, group1_stop_method,
                           speed_feedback_source_select, loop_control_mode_digit};
  wire [31:0] status_word = {24'h00_0000, option_sync, fully_closed, stop_action, stop_req,
                             speed_fb_external, param_setting_alarm, motor_load_error_overflow_alarm};
  wire [31:0] read_mux =
    (reg_addr == fcs_pkg::ADDR_CTRL)    ? ctrl_word :
    (reg_addr == fcs_pkg::ADDR_LIMIT)   ? 32'(motor_load_error_limit) :
    (reg_addr == fcs_pkg::ADDR_MULT)    ? 32'(per_rotation_error_multiplier) :
    (reg_addr == fcs_pkg::ADDR_MON_SEL) ? {16'h0000, analog_monitor2_select, analog_monitor1_select} :
    (reg_addr == fcs_pkg::ADDR_STATUS)  ? status_word :
    (reg_addr == fcs_pkg::ADDR_ERROR)   ? 32'(eff_err) : 32'h0000_0000;

  always_ff @(posedge core_clk)
  begin
    if (srst)
      reg_rdata <= '0;
    else
      reg_rdata <= reg_rd ? read_mux : 32'h0000_0000;
  end

  // ==========================================================
  // Checks
  sequence s_g2_only;
    group2_hit && !group1_hit;
  endsequence

  sequence s_restart_ext;
    restart && (speed_feedback_source_select == fcs_pkg::FB_EXTERNAL) ##1 fully_closed;
  endsequence

  ovf_raise_a: assert property (@(posedge core_clk) disable iff (srst) // (R1)
    over_limit |=> motor_load_error_overflow_alarm)
    else $error("overflow alarm missed");

  ovf_zero_limit_a: assert property (@(posedge core_clk) disable iff (srst) // (R2)
    $rose(motor_load_error_overflow_alarm) |-> $past(limit_on))
    else $error("overflow raised with zero limit");

  rot_scale_a: assert property (@(posedge core_clk) disable iff (srst) // (R3)
    (rotation_tick && !pos_valid && !mult_zero && !wr_mult) |=> (eff_err == $past(carried_err)))
    else $error("rotation carry not scaled");

  mult_zero_a: assert property (@(posedge core_clk) disable iff (srst) // (R4)
    (mult_zero && !pos_valid) |=> (eff_err == $past(raw_err)))
    else $error("correction applied with zero multiplier");

  fb_restart_a: assert property (@(posedge core_clk) disable iff (srst) // (R6)
    s_restart_ext |=> speed_fb_external)
    else $error("speed source not applied at restart");

  fb_hold_a: assert property (@(posedge core_clk) disable iff (srst) // (R6)
    (!restart && $stable(fully_closed)) ##1 $stable(fully_closed) |=> $stable(speed_fb_external))
    else $error("speed source changed without restart");

  fb_mode_a: assert property (@(posedge core_clk) disable iff (srst) // (R7)
    !fully_closed |=> !speed_fb_external)
    else $error("speed source used while semi-closed");

  g1_stop_a: assert property (@(posedge core_clk) disable iff (srst) // (R8)
    (group1_hit && group1_stop_method == fcs_pkg::DIGIT_RST) |=> (stop_action == fcs_pkg::STOP_BRAKE))
    else $error("group-one stop not dynamic brake");

  g2_stop_a: assert property (@(posedge core_clk) disable iff (srst) // (R9)
    (s_g2_only and (!torque_ctrl && group2_stop_method == fcs_pkg::DIGIT_RST))
      |=> (stop_action == fcs_pkg::STOP_ZERO_SPEED) && stop_req)
    else $error("group-two stop not zero speed");

  torque_stop_a: assert property (@(posedge core_clk) disable iff (srst) // (R10)
    (s_g2_only and torque_ctrl) |=> (stop_action == $past(g1_action)))
    else $error("torque control ignored group-one method");

  g2_same_a: assert property (@(posedge core_clk) disable iff (srst) // (R11)
    (s_g2_only and (group2_stop_method == fcs_pkg::G2_SAME_G1)) |=> (stop_action == $past(g1_action)))
    else $error("group-two did not follow group one");

  param_alarm_a: assert property (@(posedge core_clk) disable iff (srst) // (R12)
    param_clash |=> param_setting_alarm ##1 param_setting_alarm)
    else $error("parameter alarm not raised or not held");

  ovf_latch_a: assert property (@(posedge core_clk) disable iff (srst) // (R13)
    (motor_load_error_overflow_alarm && !alarm_reset) |=> motor_load_error_overflow_alarm)
    else $error("overflow alarm dropped without reset");

  ovf_clear_a: assert property (@(posedge core_clk) disable iff (srst) // (R13)
    (alarm_reset && !over_limit) |=> !motor_load_error_overflow_alarm)
    else $error("alarm reset did not clear overflow");

endmodule // fcs_supervisor

// ===== shared/fcs_pkg.sv
package fcs_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_LIMIT   = 8'h04;
  localparam logic [7:0] ADDR_MULT    = 8'h08;
  localparam logic [7:0] ADDR_MON_SEL = 8'h0c;
  localparam logic [7:0] ADDR_STATUS  = 8'h10;
  localparam logic [7:0] ADDR_ERROR   = 8'h14;
  localparam logic [7:0] ADDR_CMD     = 8'h18;

  // ==========================================================
  // Field positions and widths
  localparam int DIGIT_W        = 4;
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_FBSEL_LSB = 4;
  localparam int CTRL_G1_LSB    = 8;
  localparam int CTRL_G2_LSB    = 12;
  localparam int SEL_W          = 8;
  localparam int MON1_LSB       = 0;
  localparam int MON2_LSB       = 8;
  localparam int CMD_ALM_RST    = 0;
  localparam int CMD_RESTART    = 1;
  localparam int ST_OVERFLOW    = 0;
  localparam int ST_PARAM       = 1;
  localparam int ST_FB_EXT      = 2;
  localparam int ST_STOP_REQ    = 3;
  localparam int ST_ACTION_LSB  = 4;
  localparam int ST_FULLY       = 6;
  localparam int ST_OPTION      = 7;
  localparam int LIMIT_W        = 31;
  localparam int MULT_W         = 7;

  // ==========================================================
  // Reset values and codes
  localparam logic [LIMIT_W-1:0] LIMIT_RST    = 31'h0000_03e8;
  localparam logic [LIMIT_W-1:0] LIMIT_MAX    = 31'h4000_0000;
  localparam logic [MULT_W-1:0]  MULT_RST     = 7'h14;
  localparam logic [MULT_W-1:0]  MULT_MAX     = 7'h64;
  localparam logic [SEL_W-1:0]   MON1_RST     = 8'h02;
  localparam logic [SEL_W-1:0]   MON2_RST     = 8'h00;
  localparam logic [SEL_W-1:0]   MON_CODE_ERR = 8'h07;
  localparam logic [DIGIT_W-1:0] DIGIT_RST    = 4'h0;
  localparam logic [DIGIT_W-1:0] FB_EXTERNAL  = 4'h1;
  localparam logic [DIGIT_W-1:0] G2_SAME_G1   = 4'h1;

  typedef enum logic [1:0] {STOP_NONE, STOP_BRAKE, STOP_COAST, STOP_ZERO_SPEED} fcs_stop_e;

endpackage

// ===== tb/fcs_enc_model.sv
`timescale 1ns/10ps
module fcs_enc_model #(
  parameter int W = 32
) (
  // Clock
  input  wire logic         core_clk,
  // Position feedback toward the supervisor
  output logic     [W-1:0]  motor_pos,
  output logic     [W-1:0]  load_pos,
  output logic              pos_valid,
  output logic              rotation_tick
);
  initial
  begin
    motor_pos     = '0;
    load_pos      = '0;
    pos_valid     = 1'b0;
    rotation_tick = 1'b0;
  end

  // ==========================================================
  // One paired sample of motor and load positions
  task automatic sample(input logic [W-1:0] m, input logic [W-1:0] l);
    @(posedge core_clk);
    motor_pos <= m;
    load_pos  <= l;
    pos_valid <= 1'b1;
    @(posedge core_clk);
    pos_valid <= 1'b0;
    // Stale positions are inverted so a late capture shows up
    motor_pos <= ~m;
    load_pos  <= ~l;
  endtask

  // ==========================================================
  // One pulse per motor rotation, never beside a sample
  task automatic tick();
    @(posedge core_clk);
    rotation_tick <= 1'b1;
    @(posedge core_clk);
    rotation_tick <= 1'b0;
  endtask
endmodule // fcs_enc_model

// ===== tb/fcs_supervisor_tb.sv
`timescale 1ns/10ps
module fcs_supervisor_tb;
  logic               core_clk = 1'b0;
  logic               srst = 1'b1;
  logic        [7:0]  reg_addr = 8'h00;
  logic        [31:0] reg_wdata = 32'h0;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic        [31:0] reg_rdata;
  logic        [31:0] motor_pos;
  logic        [31:0] load_pos;
  logic               pos_valid;
  logic               rotation_tick;
  logic               torque_ctrl = 1'b0;
  logic               option_fc_pin = 1'b0;
  logic               group1_alarm_in = 1'b0;
  logic               group2_alarm_in = 1'b0;
  logic               ovf;
  logic               param_alm;
  logic               stop_req;
  fcs_pkg::fcs_stop_e stop_action;
  logic               fb_ext;
  logic signed [15:0] mon1_out;
  logic signed [15:0] mon2_out;
  int                 error_cnt = 0;
  int                 num_checks = 0;
  logic        [31:0] rv;

  always #2.5 core_clk = ~core_clk;

  fcs_supervisor #(.POS_W(32), .MON_W(16)) DUT (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .motor_pos(motor_pos), .load_pos(load_pos),
    .pos_valid(pos_valid), .rotation_tick(rotation_tick), .torque_ctrl(torque_ctrl),
    .option_fc_pin(option_fc_pin), .group1_alarm_in(group1_alarm_in), .group2_alarm_in(group2_alarm_in),
    .motor_load_error_overflow_alarm(ovf), .param_setting_alarm(param_alm), .stop_req(stop_req),
    .stop_action(stop_action), .speed_fb_external(fb_ext), .mon1_out(mon1_out), .mon2_out(mon2_out));

  fcs_enc_model #(.W(32)) enc (
    .core_clk(core_clk), .motor_pos(motor_pos), .load_pos(load_pos),
    .pos_valid(pos_valid), .rotation_tick(rotation_tick));

  // ==========================================================
  // Bus and check tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    // Read data stands only in this cycle
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic stop_test();
    $display("TB: checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    stop_test();
  end

  // ==========================================================
  // Stop method table: ctrl, torque, group1, group2, action
  logic [15:0] st_ctrl [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h1000, 16'h1200, 16'h0200, 16'h0000};
  logic [2:0]  st_in   [7] = '{3'b010, 3'b001, 3'b101, 3'b001, 3'b001, 3'b010, 3'b000};
  logic [1:0]  st_exp  [7] = '{2'h1, 2'h3, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0};

  initial
  begin
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    cyc(1);
    rdc(fcs_pkg::ADDR_LIMIT, 32'h0000_03e8);
    rdc(fcs_pkg::ADDR_MULT, 32'h0000_0014);
    rdc(fcs_pkg::ADDR_MON_SEL, 32'h0000_0002);
    rdc(fcs_pkg::ADDR_CTRL, 32'h0000_0000);
    chk({16'h0, mon1_out}, 32'h0);
    wr(fcs_pkg::ADDR_STATUS, 32'hffff_ffff);
    rdc(fcs_pkg::ADDR_STATUS, 32'h0000_0000);
    rdc(8'h1c, 32'h0000_0000);
    wr(fcs_pkg::ADDR_MULT, 32'h0000_00c8);
    rdc(fcs_pkg::ADDR_MULT, 32'h0000_0064);
    wr(fcs_pkg::ADDR_MULT, 32'h0000_0014);
    wr(fcs_pkg::ADDR_LIMIT, 32'h7fff_ffff);
    rdc(fcs_pkg::ADDR_LIMIT, 32'h4000_0000);
    wr(fcs_pkg::ADDR_LIMIT, 32'h0000_03e8);
    $display("TB: test registers done");
    for (int i = 0; i < 7; i++)
    begin
      wr(fcs_pkg::ADDR_CTRL, {16'h0, st_ctrl[i]});
      torque_ctrl     <= st_in[i][2];
      group1_alarm_in <= st_in[i][1];
      group2_alarm_in <= st_in[i][0];
      cyc(3);
      chk({30'h0, stop_action}, {30'h0, st_exp[i]});
      chk({31'h0, stop_req}, {31'h0, (st_in[i][1:0] != 2'b00)});
      @(posedge core_clk);
      torque_ctrl     <= 1'b0;
      group1_alarm_in <= 1'b0;
      group2_alarm_in <= 1'b0;
    end
    $display("TB: test stop methods done");
    wr(fcs_pkg::ADDR_CTRL, 32'h0000_0010);
    wr(fcs_pkg::ADDR_CMD, 32'h0000_0002);
    enc.sample(32'd5000, 32'd0);
    cyc(3);
    chk({31'h0, fb_ext}, 32'h0);
    chk({31'h0, ovf}, 32'h0);
    @(posedge core_clk);
    option_fc_pin <= 1'b1;
    cyc(6);
    chk({31'h0, param_alm}, 32'h1);
    $display("TB: test semi-closed done");
    // Fully closed; the option alarm stays latched until srst
    enc.sample(32'd0, 32'd0);
    // Restart on motor speed first, so the later select change must wait
    wr(fcs_pkg::ADDR_CTRL, 32'h0000_0001);
    wr(fcs_pkg::ADDR_CMD, 32'h0000_0002);
    wr(fcs_pkg::ADDR_CTRL, 32'h0000_0011);
    cyc(3);
    chk({31'h0, fb_ext}, 32'h0);
    wr(fcs_pkg::ADDR_CMD, 32'h0000_0002);
    cyc(3);
    chk({31'h0, fb_ext}, 32'h1);
    wr(fcs_pkg::ADDR_CMD, 32'h0000_0001);
    enc.sample(32'd1000, 32'd0);
    cyc(3);
    chk({31'h0, ovf}, 32'h0);
    rdc(fcs_pkg::ADDR_ERROR, 32'd1000);
    enc.sample(32'd1001, 32'd0);
    cyc(3);
    chk({31'h0, ovf}, 32'h1);
    wr(fcs_pkg::ADDR_CMD, 32'h0000_0001);
    cyc(2);
    chk({31'h0, ovf}, 32'h1);
    enc.sample(32'd500, 32'd0);
    wr(fcs_pkg::ADDR_CMD, 32'h0000_0001);
    cyc(2);
    chk({31'h0, ovf}, 32'h0);
    enc.sample(32'd0, 32'd1001);
    cyc(3);
    chk({31'h0, ovf}, 32'h1);
    wr(fcs_pkg::ADDR_LIMIT, 32'h0000_0000);
    enc.sample(32'h0001_86a0, 32'd0);
    wr(fcs_pkg::ADDR_CMD, 32'h0000_0001);
    cyc(3);
    chk({31'h0, ovf}, 32'h0);
    wr(fcs_pkg::ADDR_LIMIT, 32'd50);
    cyc(2);
    chk({31'h0, ovf}, 32'h1);
    wr(fcs_pkg::ADDR_LIMIT, 32'h4000_0000);
    enc.sample(32'd0, 32'd0);
    wr(fcs_pkg::ADDR_CMD, 32'h0000_0001);
    cyc(2);
    chk({31'h0, ovf}, 32'h0);
    $display("TB: test overflow done");
    enc.sample(32'd1000, 32'd0);
    enc.tick();
    rdc(fcs_pkg::ADDR_ERROR, 32'd800);
    enc.sample(32'd2000, 32'd0);
    rdc(fcs_pkg::ADDR_ERROR, 32'd1800);
    wr(fcs_pkg::ADDR_MULT, 32'd50);
    enc.tick();
    rdc(fcs_pkg::ADDR_ERROR, 32'd900);
    enc.sample(32'd0, 32'd1001);
    enc.tick();
    rdc(fcs_pkg::ADDR_ERROR, 32'hffff_fbe6);
    wr(fcs_pkg::ADDR_MULT, 32'd0);
    enc.sample(32'd3000, 32'd0);
    rdc(fcs_pkg::ADDR_ERROR, 32'd3000);
    enc.tick();
    rdc(fcs_pkg::ADDR_ERROR, 32'd3000);
    $display("TB: test rotation weighting done");
    wr(fcs_pkg::ADDR_MON_SEL, 32'h0000_0207);
    cyc(3);
    chk({16'h0, mon1_out}, 32'h0000_0bb8);
    chk({16'h0, mon2_out}, 32'h0);
    wr(fcs_pkg::ADDR_MON_SEL, 32'h0000_0700);
    cyc(3);
    chk({16'h0, mon1_out}, 32'h0);
    chk({16'h0, mon2_out}, 32'h0000_0bb8);
    $display("TB: test monitors done");
    stop_test();
  end
endmodule // fcs_supervisor_tb
